// ===== hdl/csr_core_regs.sv
//Contract
//- Stack pointer is 8 bits, incremented before a push or call stores data.
//- Reset loads stack pointer with 07h so first push lands at 08h.
//- Stack may sit anywhere in on-chip RAM, up to 256 bytes deep.
//- Helper register takes multiply/divide operands and results, else scratch storage.
//- Status word at D0h: carry, half carry, user0, bank high, bank low, overflow, user1, parity.
//- Carry set on add carry or subtract borrow, cleared by other arithmetic.
//- Carry is the one-bit operand and destination of Boolean instructions.
//- Half carry set on nibble carry or borrow, cleared by other arithmetic.
//- Bank bits map R0-R7 to 00h, 08h, 10h or 18h.
//- Overflow set on signed add/subtract overflow, product above 255, divide by zero.
//- Otherwise add, subtract, multiply and divide clear the overflow flag.
//- Parity bit is one when the accumulator holds an odd count of ones.
//- Two user flags are plain software storage with no side effects.
//- Each data pointer is 16 bits, reachable whole or as two bytes.
//- Two data pointers share addresses; only the selected one is seen and used.
//- Auxiliary register at A2h holds select at bit 0, flag at bit 3.
//- General flag in the auxiliary register is plain software storage.
//- Incrementing the auxiliary register toggles the select; pointers keep their values.
`timescale 1ns/1ps
module csr_core_regs
    import csr_pkg::*;
(
    input  wire         core_clk,        // Core clock, 125 MHz
    input  wire         rst,             // Synchronous reset, active high
    input  wire  [7:0]  bus_addr,        // Register address
    input  wire  [7:0]  bus_wdata,       // Register write data
    input  wire         bus_wr,          // Write strobe
    input  wire         bus_rd,          // Read strobe
    output logic [7:0]  bus_rdata_q,     // Read data, cycle after strobe
    input  wire  [7:0]  acc_in,          // Accumulator contents
    input  wire         push_req,        // Push or call store
    input  wire         pop_req,         // Pop or return read done
    input  csr_arith_t  arith_op,        // Arithmetic operation
    input  wire         arith_valid,     // Arithmetic flag update
    input  wire  [7:0]  arith_a,         // First operand
    input  wire  [7:0]  arith_b,         // Second operand
    input  wire         md_wr,           // Multiply/divide result to helper
    input  wire  [7:0]  md_data,         // Result byte for helper
    input  wire         bit_cy_wr,       // Boolean write of carry
    input  wire         bit_cy_val,      // Boolean carry value
    input  wire         data_pointer_ld,         // Load selected pointer
    input  wire  [15:0] data_pointer_val,        // Value for pointer load
    input  wire         data_pointer_inc,        // Increment selected pointer
    input  wire         aux_inc,         // Increment auxiliary register
    output logic [7:0]  stack_pointer_q, // Stack pointer
    output logic [7:0]  psw_q,           // Status word
    output logic [7:0]  helper_q,        // Multiply/divide helper
    output logic [7:0]  bank_base_q,     // Base of working registers
    output logic [15:0] data_pointer_q,  // Selected pointer
    output logic        pointer_select_q // Pointer select
);
    logic [7:0] sp_d;
    logic [7:0] psw_d;
    logic [7:0] helper_d;
    logic [7:0] aux_q;
    logic [7:0] aux_d;
    logic [7:0] rd_mux;
    logic       wr_sp;
    logic       wr_psw;
    logic       wr_aux;
    logic       wr_b;
    logic       fl_cy;
    logic       fl_ac;
    logic       fl_ov;

    assign wr_sp  = bus_wr && (bus_addr == SP_ADDR);
    assign wr_psw = bus_wr && (bus_addr == PSW_ADDR);
    assign wr_aux = bus_wr && (bus_addr == AUX1_ADDR);
    assign wr_b   = bus_wr && (bus_addr == B_ADDR);

    csr_flag_unit u_flags (
        .op  (arith_op),
        .a   (arith_a),
        .b   (arith_b),
        .cin (psw_q[CY_BIT]),
        .cy  (fl_cy),
        .ac  (fl_ac),
        .ov  (fl_ov)
    );

    // A software write is taken first; a push or pop in the same cycle
    // is dropped because the write states the intended pointer outright.
    always_comb begin
        sp_d = stack_pointer_q;
        if (wr_sp) begin
            sp_d = bus_wdata;
        end else if (push_req && !pop_req) begin
            sp_d = stack_pointer_q + 8'h01;
        end else if (pop_req && !push_req) begin
            sp_d = stack_pointer_q - 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) stack_pointer_q <= SP_RST;
        else stack_pointer_q <= sp_d;
    end

    // Hardware flag updates are applied after a software write so that an
    // event never gets lost to a clear in the same cycle.
    always_comb begin
        psw_d = psw_q;
        if (wr_psw) begin
            psw_d[7:1] = bus_wdata[7:1];
        end
        if (arith_valid) begin
            psw_d[CY_BIT] = fl_cy;
            psw_d[AC_BIT] = fl_ac;
            psw_d[OV_BIT] = fl_ov;
        end
        if (bit_cy_wr) begin
            psw_d[CY_BIT] = bit_cy_val;
        end
        psw_d[P_BIT] = ^acc_in;
    end

    always_ff @(posedge core_clk) begin
        if (rst) psw_q <= PSW_RST;
        else psw_q <= psw_d;
    end

    always_ff @(posedge core_clk) begin
        if (rst) bank_base_q <= 8'h00;
        else bank_base_q <= {3'b000, psw_d[RSH_BIT], psw_d[RSL_BIT], 3'b000};
    end

    always_comb begin
        helper_d = helper_q;
        if (md_wr) helper_d = md_data;
        else if (wr_b) helper_d = bus_wdata;
    end

    always_ff @(posedge core_clk) begin
        if (rst) helper_q <= B_RST;
        else helper_q <= helper_d;
    end

    always_comb begin
        aux_d = aux_q;
        if (wr_aux) aux_d = bus_wdata & AUX1_MASK;
        if (aux_inc) aux_d[SEL_BIT] = !aux_d[SEL_BIT];
    end

    always_ff @(posedge core_clk) begin
        if (rst) aux_q <= AUX1_RST;
        else aux_q <= aux_d;
    end

    always_ff @(posedge core_clk) begin
        if (rst) pointer_select_q <= 1'b0;
        else pointer_select_q <= aux_d[SEL_BIT];
    end

    csr_data_pointer_bank u_data_pointer (
        .core_clk (core_clk),
        .rst      (rst),
        .sel_q    (aux_q[SEL_BIT]),
        .sel_d    (aux_d[SEL_BIT]),
        .wr_lo    (bus_wr && (bus_addr == DPL_ADDR)),
        .wr_hi    (bus_wr && (bus_addr == DPH_ADDR)),
        .wdata    (bus_wdata),
        .ld16     (data_pointer_ld),
        .val16    (data_pointer_val),
        .inc      (data_pointer_inc),
        .cur_q    (data_pointer_q)
    );

    // Reads see the state before any write in the same cycle.
    always_comb begin
        unique case (bus_addr)
            SP_ADDR:   rd_mux = stack_pointer_q;
            DPL_ADDR:  rd_mux = data_pointer_q[7:0];
            DPH_ADDR:  rd_mux = data_pointer_q[15:8];
            AUX1_ADDR: rd_mux = aux_q;
            PSW_ADDR:  rd_mux = psw_q;
            B_ADDR:    rd_mux = helper_q;
            default:   rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) bus_rdata_q <= 8'h00;
        else bus_rdata_q <= bus_rd ? rd_mux : 8'h00;
    end

    a_sp_reset_val: assert property (@(posedge core_clk)
        rst |=> stack_pointer_q == SP_RST)
        else $error("stack pointer not 07h after reset");

    a_sp_push_inc: assert property (@(posedge core_clk) disable iff (rst)
        push_req && !pop_req && !wr_sp |=>
        stack_pointer_q == $past(stack_pointer_q) + 8'h01)
        else $error("push did not increment stack pointer");

    a_sp_full_wrap: assert property (@(posedge core_clk) disable iff (rst)
        stack_pointer_q == 8'hff && push_req && !pop_req && !wr_sp
        |=> stack_pointer_q == 8'h00)
        else $error("stack pointer did not wrap");

    a_parity_track: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> psw_q[P_BIT] == ^$past(acc_in))
        else $error("parity does not follow accumulator");

    a_bank_map_base: assert property (@(posedge core_clk) disable iff (rst)
        bank_base_q == {3'b000, psw_q[RSH_BIT], psw_q[RSL_BIT], 3'b000})
        else $error("bank base does not match select bits");

    a_mul_ovf_flag: assert property (@(posedge core_clk) disable iff (rst)
        arith_valid && arith_op == OP_MUL |=>
        psw_q[OV_BIT] == ($past(arith_a) * $past(arith_b) > 255))
        else $error("multiply overflow flag wrong");

    a_div_zero_flag: assert property (@(posedge core_clk) disable iff (rst)
        arith_valid && arith_op == OP_DIV |=>
        psw_q[OV_BIT] == ($past(arith_b) == 8'h00))
        else $error("divide overflow flag wrong");

    a_md_carry_clr: assert property (@(posedge core_clk) disable iff (rst)
        arith_valid && arith_op inside {OP_MUL, OP_DIV} && !bit_cy_wr
        |=> !psw_q[CY_BIT] && !psw_q[AC_BIT])
        else $error("carry not cleared by multiply or divide");

    a_user_flag_hold: assert property (@(posedge core_clk) disable iff (rst)
        !wr_psw |=> psw_q[F0_BIT] == $past(psw_q[F0_BIT])
        && psw_q[F1_BIT] == $past(psw_q[F1_BIT]))
        else $error("user flag changed without write");

    a_sel_inc_toggle: assert property (@(posedge core_clk) disable iff (rst)
        aux_inc && !wr_aux |=> pointer_select_q != $past(pointer_select_q))
        else $error("increment did not toggle select");

    a_helper_result: assert property (@(posedge core_clk) disable iff (rst)
        md_wr |=> helper_q == $past(md_data))
        else $error("helper did not take result");

    a_sp_pop_dec: assert property (@(posedge core_clk) disable iff (rst)
        pop_req && !push_req && !wr_sp |=> stack_pointer_q == $past(stack_pointer_q) - 8'h01)
        else $error("pop did not decrement stack pointer");

    a_sp_both_hold: assert property (@(posedge core_clk) disable iff (rst)
        push_req && pop_req && !wr_sp |=> stack_pointer_q == $past(stack_pointer_q))
        else $error("push with pop moved stack pointer");

    a_sp_sw_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_sp |=> stack_pointer_q == $past(bus_wdata))
        else $error("stack pointer write lost");

    a_add_carry_out: assert property (@(posedge core_clk) disable iff (rst)
        arith_valid && arith_op == OP_ADD && !bit_cy_wr |=> psw_q[CY_BIT] ==
        (({1'b0, $past(arith_a)} + {1'b0, $past(arith_b)}) >= 9'h100))
        else $error("add carry wrong");

    a_add_half_out: assert property (@(posedge core_clk) disable iff (rst)
        arith_valid && arith_op == OP_ADD |=> psw_q[AC_BIT] ==
        (({1'b0, $past(arith_a[3:0])} + {1'b0, $past(arith_b[3:0])}) >= 5'h10))
        else $error("add half carry wrong");

    a_subtract_borrow_op_borrow_out: assert property (@(posedge core_clk) disable iff (rst)
        arith_valid && arith_op == OP_SUBTRACT_BORROW_OP && !bit_cy_wr |=> psw_q[CY_BIT] ==
        ({1'b0, $past(arith_a)} < ({1'b0, $past(arith_b)} + {8'h00, $past(psw_q[CY_BIT])})))
        else $error("subtract borrow wrong");

    a_bool_carry_wr: assert property (@(posedge core_clk) disable iff (rst)
        bit_cy_wr |=> psw_q[CY_BIT] == $past(bit_cy_val))
        else $error("Boolean carry write lost");

    a_flags_hold: assert property (@(posedge core_clk) disable iff (rst)
        !arith_valid && !bit_cy_wr && !wr_psw |=> psw_q[7:6] == $past(psw_q[7:6])
        && psw_q[OV_BIT] == $past(psw_q[OV_BIT]))
        else $error("arithmetic flags changed without cause");

    a_psw_sw_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_psw && !arith_valid && !bit_cy_wr |=> psw_q[7:1] == $past(bus_wdata[7:1]))
        else $error("status word write lost");

    a_bank_hold: assert property (@(posedge core_clk) disable iff (rst)
        !wr_psw |=> psw_q[4:3] == $past(psw_q[4:3]))
        else $error("bank select changed without write");

    a_helper_sw_wr: assert property (@(posedge core_clk) disable iff (rst)
        wr_b && !md_wr |=> helper_q == $past(bus_wdata))
        else $error("helper write lost");

    a_helper_hold: assert property (@(posedge core_clk) disable iff (rst)
        !wr_b && !md_wr |=> helper_q == $past(helper_q))
        else $error("helper changed without write");

    a_aux_write_mask: assert property (@(posedge core_clk) disable iff (rst)
        wr_aux && !aux_inc |=> aux_q == ($past(bus_wdata) & AUX1_MASK))
        else $error("auxiliary write wrong");

    a_aux_unused_zero: assert property (@(posedge core_clk) disable iff (rst)
        (aux_q & ~AUX1_MASK) == 8'h00)
        else $error("unused auxiliary bit set");

    a_aux_hold: assert property (@(posedge core_clk) disable iff (rst)
        !wr_aux && !aux_inc |=> aux_q == $past(aux_q))
        else $error("auxiliary changed without cause");

    a_sel_matches_aux: assert property (@(posedge core_clk) disable iff (rst)
        pointer_select_q == aux_q[SEL_BIT])
        else $error("select output differs from register");

    a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
        !bus_rd |=> bus_rdata_q == 8'h00)
        else $error("read data not cleared");

    a_rdata_sp: assert property (@(posedge core_clk) disable iff (rst)
        bus_rd && bus_addr == SP_ADDR |=> bus_rdata_q == $past(stack_pointer_q))
        else $error("stack pointer read wrong");

    a_rdata_psw: assert property (@(posedge core_clk) disable iff (rst)
        bus_rd && bus_addr == PSW_ADDR |=> bus_rdata_q == $past(psw_q))
        else $error("status word read wrong");

    a_rdata_dpl: assert property (@(posedge core_clk) disable iff (rst)
        bus_rd && bus_addr == DPL_ADDR |=> bus_rdata_q == $past(data_pointer_q[7:0]))
        else $error("pointer low byte read wrong");

    a_rdata_helper: assert property (@(posedge core_clk) disable iff (rst)
        bus_rd && bus_addr == B_ADDR |=> bus_rdata_q == $past(helper_q))
        else $error("helper read wrong");

    a_rdata_aux: assert property (@(posedge core_clk) disable iff (rst)
        bus_rd && bus_addr == AUX1_ADDR |=> bus_rdata_q == $past(aux_q))
        else $error("auxiliary read wrong");

    a_ptr_load: assert property (@(posedge core_clk) disable iff (rst)
        data_pointer_ld && !aux_inc && !wr_aux |=> data_pointer_q == $past(data_pointer_val))
        else $error("pointer load lost");

    a_ptr_inc: assert property (@(posedge core_clk) disable iff (rst)
        data_pointer_inc && !data_pointer_ld && !aux_inc && !wr_aux |=>
        data_pointer_q == $past(data_pointer_q) + 16'h0001)
        else $error("pointer increment wrong");

    c_div_zero: cover property (@(posedge core_clk) disable iff (rst)
        arith_valid && arith_op == OP_DIV && arith_b == 8'h00);
    c_bank_three: cover property (@(posedge core_clk) disable iff (rst)
        bank_base_q == 8'h18);
    c_push_pop: cover property (@(posedge core_clk) disable iff (rst)
        push_req ##1 pop_req);
    c_sel_swap: cover property (@(posedge core_clk) disable iff (rst)
        aux_inc ##1 data_pointer_inc ##1 aux_inc);
    c_mul_ovf: cover property (@(posedge core_clk) disable iff (rst)
        arith_valid && arith_op == OP_MUL && fl_ov);
endmodule : csr_core_regs

// ===== hdl/csr_pkg.sv
package csr_pkg;
    // Register addresses in the special-register space.
    localparam logic [7:0] SP_ADDR   = 8'h81;
    localparam logic [7:0] DPL_ADDR  = 8'h82;
    localparam logic [7:0] DPH_ADDR  = 8'h83;
    localparam logic [7:0] AUX1_ADDR = 8'ha2;
    localparam logic [7:0] PSW_ADDR  = 8'hd0;
    localparam logic [7:0] B_ADDR    = 8'hf0;
    // Reset values.
    localparam logic [7:0]  SP_RST   = 8'h07;
    localparam logic [7:0]  PSW_RST  = 8'h00;
    localparam logic [7:0]  AUX1_RST = 8'h00;
    localparam logic [7:0]  B_RST    = 8'h00;
    localparam logic [15:0] DATA_POINTER_RST = 16'h0000;
    // Status word fields.
    localparam int CY_BIT  = 7;
    localparam int AC_BIT  = 6;
    localparam int F0_BIT  = 5;
    localparam int RSH_BIT = 4;
    localparam int RSL_BIT = 3;
    localparam int OV_BIT  = 2;
    localparam int F1_BIT  = 1;
    localparam int P_BIT   = 0;
    // Auxiliary register fields; only these bits are stored.
    localparam int SEL_BIT = 0;
    localparam int GF2_BIT = 3;
    localparam logic [7:0] AUX1_MASK = 8'h09;
    typedef enum logic [2:0] {
        OP_ADD,
        OP_ADD_WITH_CARRY_OP,
        OP_SUBTRACT_BORROW_OP,
        OP_MUL,
        OP_DIV
    } csr_arith_t;
endpackage : csr_pkg

// ===== hdl/csr_flag_unit.sv
`timescale 1ns/1ps
module csr_flag_unit
    import csr_pkg::*;
(
    input  csr_arith_t op,     // Arithmetic operation
    input  wire  [7:0] a,      // First operand
    input  wire  [7:0] b,      // Second operand
    input  wire        cin,    // Carry in
    output logic       cy,     // Carry or borrow
    output logic       ac,     // Nibble carry or borrow
    output logic       ov      // Overflow
);
    logic [8:0]  sum;
    logic [4:0]  low;
    logic [15:0] prod;
    logic        ci;

    always_comb begin
        ci   = (op == OP_ADD_WITH_CARRY_OP || op == OP_SUBTRACT_BORROW_OP) ? cin : 1'b0;
        sum  = 9'h000;
        low  = 5'h00;
        prod = a * b;
        cy   = 1'b0;
        ac   = 1'b0;
        ov   = 1'b0;
        unique case (op)
            OP_ADD, OP_ADD_WITH_CARRY_OP: begin
                sum = {1'b0, a} + {1'b0, b} + {8'h00, ci};
                low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
                cy  = sum[8];
                ac  = low[4];
                ov  = (a[7] == b[7]) && (sum[7] != a[7]);
            end
            OP_SUBTRACT_BORROW_OP: begin
                sum = {1'b0, a} - {1'b0, b} - {8'h00, ci};
                low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
                cy  = sum[8];
                ac  = low[4];
                ov  = (a[7] != b[7]) && (sum[7] != a[7]);
            end
            OP_MUL: ov = |prod[15:8];
            OP_DIV: ov = (b == 8'h00);
            default: ov = 1'b0;
        endcase
    end
endmodule : csr_flag_unit

// ===== hdl/csr_data_pointer_bank.sv
`timescale 1ns/1ps
module csr_data_pointer_bank
    import csr_pkg::*;
(
    input  wire         core_clk, // Core clock
    input  wire         rst,      // Synchronous reset, active high
    input  wire         sel_q,    // Select in force this cycle
    input  wire         sel_d,    // Select for the next cycle
    input  wire         wr_lo,    // Write low byte
    input  wire         wr_hi,    // Write high byte
    input  wire  [7:0]  wdata,    // Byte write data
    input  wire         ld16,     // Load whole pointer
    input  wire  [15:0] val16,    // Whole pointer value
    input  wire         inc,      // Increment pointer
    output logic [15:0] cur_q     // Pointer selected now
);
    logic [15:0] ptr_q [2];
    logic [15:0] ptr_d [2];

    for (genvar i = 0; i < 2; i++) begin : g_ptr
        always_comb begin
            ptr_d[i] = ptr_q[i];
            if (sel_q == 1'(i)) begin
                if (ld16) begin
                    ptr_d[i] = val16;
                end else if (inc) begin
                    ptr_d[i] = ptr_q[i] + 16'h0001;
                end else begin
                    if (wr_lo) ptr_d[i][7:0] = wdata;
                    if (wr_hi) ptr_d[i][15:8] = wdata;
                end
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) ptr_q[i] <= DATA_POINTER_RST;
            else ptr_q[i] <= ptr_d[i];
        end

        a_unsel_hold: assert property (@(posedge core_clk) disable iff (rst)
            sel_q != 1'(i) |=> ptr_q[i] == $past(ptr_q[i]))
            else $error("unselected pointer changed");
    end

    always_ff @(posedge core_clk) begin
        if (rst) cur_q <= DATA_POINTER_RST;
        else cur_q <= ptr_d[sel_d];
    end
endmodule : csr_data_pointer_bank

// ===== verification/csr_core_regs_tb_top.sv
`timescale 1ns/1ps
module csr_core_regs_tb_top;
    import csr_pkg::*;
    logic        core_clk, rst, bus_wr, bus_rd, push_req, pop_req, arith_valid, md_wr;
    logic        bit_cy_wr, bit_cy_val, data_pointer_ld, data_pointer_inc, aux_inc, pointer_select_q, rd_d;
    logic [7:0]  bus_addr, bus_wdata, bus_rdata_q, acc_in, arith_a, arith_b, md_data;
    logic [7:0]  stack_pointer_q, psw_q, helper_q, bank_base_q, a, b, e;
    logic [15:0] data_pointer_val, data_pointer_q;
    logic [8:0]  t;
    logic [4:0]  h;
    logic        c, ci, ey, eh, ev;
    csr_arith_t  arith_op, o;
    logic [7:0]  exp_q[$];
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          k;

    csr_core_regs i_csr_core_regs (.core_clk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
        .bus_rdata_q, .acc_in, .push_req, .pop_req, .arith_op, .arith_valid, .arith_a,
        .arith_b, .md_wr, .md_data, .bit_cy_wr, .bit_cy_val, .data_pointer_ld, .data_pointer_val, .data_pointer_inc,
        .aux_inc, .stack_pointer_q, .psw_q, .helper_q, .bank_base_q, .data_pointer_q,
        .pointer_select_q);

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // Every strobe is dropped together, then outputs are looked at once they settle.
    task automatic fire();
        @(posedge core_clk);
        {bus_wr, bus_rd, push_req, pop_req, arith_valid} <= '0;
        {md_wr, bit_cy_wr, data_pointer_ld, data_pointer_inc, aux_inc} <= '0;
        @(negedge core_clk);
    endtask : fire

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= ad;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        fire();
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [7:0] ex);
        @(posedge core_clk);
        bus_addr <= ad;
        bus_rd <= 1'b1;
        exp_q.push_back(ex);
        fire();
    endtask : rd

    task automatic pulse(input int w, input logic [15:0] d = 16'h0000,
                         input csr_arith_t op = OP_ADD);
        @(posedge core_clk);
        {arith_b, arith_a} <= d;
        md_data <= d[7:0];
        data_pointer_val <= d;
        bit_cy_val <= d[0];
        arith_op <= op;
        case (w)
            0: push_req <= 1'b1;
            1: pop_req <= 1'b1;
            2: arith_valid <= 1'b1;
            3: md_wr <= 1'b1;
            4: bit_cy_wr <= 1'b1;
            5: data_pointer_ld <= 1'b1;
            6: data_pointer_inc <= 1'b1;
            default: aux_inc <= 1'b1;
        endcase
        fire();
    endtask : pulse

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Read data are due only in the cycle after the strobe, so they are checked there.
    always @(posedge core_clk) rd_d <= bus_rd;
    always @(negedge core_clk) begin
        if (rd_d === 1'b1) begin
            if (exp_q.size() == 0)
                chk(16'h0000, 16'hffff);
            else
                chk(16'(bus_rdata_q), 16'(exp_q.pop_front()));
        end
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        rst = 1'b1;
        {bus_wr, bus_rd, push_req, pop_req, arith_valid, md_wr, bit_cy_wr} = '0;
        {bit_cy_val, data_pointer_ld, data_pointer_inc, aux_inc} = '0;
        {bus_addr, bus_wdata, acc_in, arith_a, arith_b, md_data} = '0;
        data_pointer_val = 16'h0000;
        arith_op = OP_ADD;
        void'($urandom(8));
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd(SP_ADDR, SP_RST);
        rd(PSW_ADDR, PSW_RST);
        rd(AUX1_ADDR, AUX1_RST);
        rd(B_ADDR, B_RST);
        rd(DPH_ADDR, 8'h00);
        rd(8'h55, 8'h00);
        pulse(0);
        pulse(0);
        chk(16'(stack_pointer_q), 16'h0009);
        pulse(1);
        rd(SP_ADDR, 8'h08);
        wr(SP_ADDR, 8'hff);
        pulse(0);
        chk(16'(stack_pointer_q), 16'h0000);
        for (k = 0; k < 4; k++) begin
            e = {3'b001, 2'(k), 3'b010};
            wr(PSW_ADDR, e);
            chk(16'(bank_base_q), 16'(k * 8));
            rd(PSW_ADDR, e);
        end
        for (k = 0; k < 8; k++) begin
            a = 8'($urandom);
            @(posedge core_clk);
            acc_in <= a;
            wr(PSW_ADDR, 8'hff);
            rd(PSW_ADDR, {7'h7f, ^a});
        end
        wr(PSW_ADDR, 8'h00);
        for (k = 0; k < 40; k++) begin
            a = 8'($urandom);
            b = (k % 9 == 4) ? 8'h00 : 8'($urandom);
            c = 1'($urandom);
            o = csr_arith_t'(k % 5);
            pulse(4, {15'h0000, c});
            chk(16'(psw_q[CY_BIT]), 16'(c));
            pulse(2, {b, a}, o);
            ci = (o == OP_ADD_WITH_CARRY_OP) ? c : 1'b0;
            t = {1'b0, a} + {1'b0, b} + 9'(ci);
            h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
            ev = (a[7] == b[7]) && (t[7] != a[7]);
            if (o == OP_SUBTRACT_BORROW_OP) begin
                t = {1'b0, a} - {1'b0, b} - 9'(c);
                h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(c);
                ev = (a[7] != b[7]) && (t[7] != a[7]);
            end
            ey = t[8];
            eh = h[4];
            if (o == OP_MUL || o == OP_DIV) begin
                ey = 1'b0;
                eh = 1'b0;
                ev = (o == OP_MUL) ? (16'(a) * 16'(b) > 16'd255) : (b == 8'h00);
            end
            chk(16'({psw_q[CY_BIT], psw_q[AC_BIT], psw_q[OV_BIT]}), 16'({ey, eh, ev}));
        end
        wr(B_ADDR, 8'h5a);
        rd(B_ADDR, 8'h5a);
        pulse(3, 16'h00c3);
        chk(16'(helper_q), 16'h00c3);
        wr(DPL_ADDR, 8'h34);
        wr(DPH_ADDR, 8'h12);
        chk(data_pointer_q, 16'h1234);
        pulse(7);
        chk(16'(pointer_select_q), 16'h0001);
        chk(data_pointer_q, DATA_POINTER_RST);
        pulse(5, 16'hffff);
        pulse(6);
        chk(data_pointer_q, 16'h0000);
        pulse(6);
        rd(DPL_ADDR, 8'h01);
        pulse(7);
        chk(data_pointer_q, 16'h1234);
        pulse(6);
        chk(data_pointer_q, 16'h1235);
        wr(AUX1_ADDR, 8'hff);
        rd(AUX1_ADDR, AUX1_MASK);
        chk(16'(pointer_select_q), 16'h0001);
        rd(DPL_ADDR, 8'h01);
        repeat (3) @(posedge core_clk);
        end_of_test();
    end
endmodule : csr_core_regs_tb_top
